//--- vfm_mux.sv
`timescale 1ns/1ps
module vfm_mux
  import vfm_pkg::*;
#(
  parameter int DW = 32
)(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic [vfm_pkg::AW-1:0] paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic                     irq,
  input  wire logic [1:0]          rx_valid,
  input  wire logic [1:0][DW-1:0]  rx_data,
  input  wire logic [1:0]          rx_last,
  input  wire logic [1:0]          rx_long,
  output logic      [1:0]          rx_ready,
  output logic                     tx0_valid,
  output logic      [DW-1:0]       tx0_data,
  output logic                     tx0_last,
  output logic                     tx0_src,
  input  wire logic                tx0_ready,
  output logic                     tx1_valid,
  output logic      [DW-1:0]       tx1_data,
  output logic                     tx1_last,
  input  wire logic                tx1_ready
);
  import vfm_pkg::*;

  function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] idx);
    hit = (a == {{(AW-10){1'b0}}, idx, 2'b00});
  endfunction : hit

  function automatic logic rr_pick(input logic [1:0] m, input logic last);
    rr_pick = m[~last] ? ~last : last;
  endfunction : rr_pick

  logic [7:0]  port_dis_ff;
  logic [7:0]  mode_ff;
  logic [1:0]  irq_sts_ff;
  logic [1:0]  irq_msk_ff;
  logic        sync_sts_ff;
  logic        sync_fail_ff;
  logic        seen_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] prdata_ff;
  logic        irq_ff;
  vfm_state_t  state_ff;
  logic        src_ff;
  logic        last_src_ff;
  logic [1:0]  pend_ff;
  logic        grp_ff;
  logic [1:0]  rdy_ff;
  logic [15:0] wait_cnt_ff;
  logic        tx0_valid_ff;
  logic        tx1_valid_ff;
  logic [DW-1:0] tx_data_ff;
  logic        tx_last_ff;
  logic        tx_src_ff;

  logic        acc;
  logic        done;
  logic        wr;
  logic        rd_sts;
  logic [1:0]  enabled;
  logic [1:0]  avail;
  logic        all_rdy;
  vfm_sync_t   smode;
  logic        rr_on;
  logic        as_avail;
  logic        repl;
  logic        pick;
  logic        pick_src;
  logic        pick_grp;
  logic [1:0]  pick_pend;
  logic        accept;
  logic        line_end;
  logic        grp_done;
  logic        sync_wait;
  logic        timeout;
  logic        fail_evt;
  logic        lock_evt;
  logic        drain;
  logic        line_nxt;
  logic        src_nxt;
  logic [31:0] rd_mux;
  logic        rd_hit;

  assign acc    = psel && penable;
  assign done   = acc && pready_ff;
  assign wr     = done && pwrite;
  assign rd_sts = done && !pwrite && hit(paddr, IDX_STS);

  assign enabled  = {~port_dis_ff[BIT_P1_DIS], ~port_dis_ff[BIT_P0_DIS]};
  assign avail    = rx_valid & enabled;
  assign all_rdy  = (enabled != 2'h0) && (avail == enabled);
  assign smode    = vfm_sync_t'(mode_ff[SYNC_LSB+1:SYNC_LSB]);
  assign rr_on    = mode_ff[BIT_RR];
  assign as_avail = mode_ff[BIT_AS_AVAIL] && (smode != SYNC_CONCAT);
  assign repl     = mode_ff[BIT_REPL];

  // Choice of the next line to forward while idle
  always_comb
  begin
    pick      = 1'b0;
    pick_src  = 1'b0;
    pick_grp  = 1'b0;
    pick_pend = 2'h0;
    if (pend_ff != 2'h0)
    begin
      pick      = 1'b1;
      pick_grp  = 1'b1;
      pick_src  = !pend_ff[0];
      pick_pend = pend_ff & ~(2'h1 << pick_src);
    end
    else if (smode != SYNC_OFF)
    begin
      if (all_rdy)
      begin
        pick      = 1'b1;
        pick_grp  = 1'b1;
        pick_src  = !enabled[0];
        pick_pend = enabled & ~(2'h1 << pick_src);
      end
      else if (as_avail && ((avail & rx_long) != 2'h0))
      begin
        pick     = 1'b1;
        pick_src = rr_pick(avail & rx_long, last_src_ff);
      end
    end
    else if (rr_on && (avail != 2'h0))
    begin
      pick     = 1'b1;
      pick_src = rr_pick(avail, last_src_ff);
    end
  end

  assign drain    = tx0_ready && (tx1_ready || !tx1_valid_ff);
  assign accept   = (state_ff == ST_LINE) && rx_valid[src_ff] && rdy_ff[src_ff];
  assign line_end = accept && rx_last[src_ff];
  assign grp_done = line_end && grp_ff && (pend_ff == 2'h0);
  assign line_nxt = (state_ff == ST_IDLE) ? pick : !line_end;
  assign src_nxt  = (state_ff == ST_IDLE) ? pick_src : src_ff;
  assign sync_wait = (smode != SYNC_OFF) && (state_ff == ST_IDLE) && !pick
                     && (avail != 2'h0);
  assign timeout  = sync_wait && (wait_cnt_ff == 16'(SYNC_TIMEOUT_CYC - 1));
  assign fail_evt = timeout && seen_ff;
  assign lock_evt = grp_done && !sync_sts_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff    <= ST_IDLE;
      src_ff      <= 1'b0;
      pend_ff     <= 2'h0;
      grp_ff      <= 1'b0;
      last_src_ff <= 1'b1;
    end
    else if (state_ff == ST_IDLE)
    begin
      if (pick)
      begin
        state_ff <= ST_LINE;
        src_ff   <= pick_src;
        pend_ff  <= pick_pend;
        grp_ff   <= pick_grp;
      end
    end
    else if (line_end)
    begin
      state_ff    <= ST_IDLE;
      last_src_ff <= src_ff;
    end
  end

  // One beat in flight: a port is ready only while the output slot frees up
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_rdy
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          rdy_ff[i] <= 1'b0;
        else
          rdy_ff[i] <= line_nxt && (src_nxt == i) && !accept && (!tx0_valid_ff || drain);
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx0_valid_ff <= 1'b0;
      tx1_valid_ff <= 1'b0;
      tx_data_ff   <= '0;
      tx_last_ff   <= 1'b0;
      tx_src_ff    <= 1'b0;
    end
    else if (accept)
    begin
      tx0_valid_ff <= 1'b1;
      tx1_valid_ff <= repl;
      tx_data_ff   <= rx_data[src_ff];
      tx_last_ff   <= rx_last[src_ff] && !((smode == SYNC_CONCAT) && (pend_ff != 2'h0));
      tx_src_ff    <= src_ff;
    end
    else if (drain)
    begin
      tx0_valid_ff <= 1'b0;
      tx1_valid_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wait_cnt_ff <= '0;
    else if (!sync_wait || timeout)
      wait_cnt_ff <= '0;
    else
      wait_cnt_ff <= wait_cnt_ff + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_sts_ff <= 1'b0;
      seen_ff     <= 1'b0;
    end
    else if (smode == SYNC_OFF)
    begin
      sync_sts_ff <= 1'b0;
      seen_ff     <= 1'b0;
    end
    else if (grp_done)
    begin
      sync_sts_ff <= 1'b1;
      seen_ff     <= 1'b1;
    end
    else if (timeout)
      sync_sts_ff <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_fail_ff <= 1'b0;
    else if (fail_evt)
      sync_fail_ff <= 1'b1;
    else if (rd_sts)
      sync_fail_ff <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_dis_ff <= RST_PORT_DIS;
      mode_ff     <= RST_MODE;
      irq_msk_ff  <= 2'h0;
    end
    else if (wr)
    begin
      if (hit(paddr, IDX_PORT_DIS))
        port_dis_ff <= pwdata[7:0] & WM_PORT_DIS;
      if (hit(paddr, IDX_MODE))
        mode_ff <= pwdata[7:0] & WM_MODE;
      if (hit(paddr, IDX_IRQ_MSK))
        irq_msk_ff <= pwdata[1:0];
    end
  end

  // Events win over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_sts_ff <= 2'h0;
    else
      irq_sts_ff <= (irq_sts_ff & ~((wr && hit(paddr, IDX_IRQ_STS)) ? pwdata[1:0] : 2'h0))
                    | {lock_evt, fail_evt};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(irq_sts_ff & irq_msk_ff);
  end

  always_comb
  begin
    rd_mux = 32'h0;
    rd_hit = 1'b1;
    if (hit(paddr, IDX_PORT_DIS))
      rd_mux[7:0] = port_dis_ff;
    else if (hit(paddr, IDX_MODE))
      rd_mux[7:0] = mode_ff;
    else if (hit(paddr, IDX_STS))
    begin
      rd_mux[BIT_SYNC_STS] = sync_sts_ff;
      rd_mux[BIT_SYNC_FL]  = sync_fail_ff;
    end
    else if (hit(paddr, IDX_IRQ_STS))
      rd_mux[1:0] = irq_sts_ff;
    else if (hit(paddr, IDX_IRQ_MSK))
      rd_mux[1:0] = irq_msk_ff;
    else
      rd_hit = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
    end
    else
    begin
      pready_ff  <= acc && !pready_ff;
      pslverr_ff <= acc && !pready_ff && !rd_hit;
      if (acc && !pready_ff && !pwrite)
        prdata_ff <= rd_mux;
    end
  end

  assign prdata    = prdata_ff;
  assign pready    = pready_ff;
  assign pslverr   = pslverr_ff;
  assign irq       = irq_ff;
  assign rx_ready  = rdy_ff;
  assign tx0_valid = tx0_valid_ff;
  assign tx0_data  = tx_data_ff;
  assign tx0_last  = tx_last_ff;
  assign tx0_src   = tx_src_ff;
  assign tx1_valid = tx1_valid_ff;
  assign tx1_data  = tx_data_ff;
  assign tx1_last  = tx_last_ff;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_P1_BLOCK: assert property ((state_ff == ST_IDLE) && port_dis_ff[BIT_P1_DIS]
    |=> !((state_ff == ST_LINE) && src_ff && !grp_ff)) else $error("port 1 forwarded");
  AST_P0_BLOCK: assert property ((state_ff == ST_IDLE) && port_dis_ff[BIT_P0_DIS]
    && (pend_ff == 2'h0) |=> !((state_ff == ST_LINE) && !src_ff)) else $error("port 0 fwd");
  AST_REPL: assert property (accept && repl
    |=> tx1_valid && (tx1_data == tx0_data)) else $error("replica missing");
  AST_SYNC_WAIT: assert property ((state_ff == ST_IDLE) && (smode != SYNC_OFF)
    && !as_avail && (pend_ff == 2'h0) && !all_rdy |=> state_ff == ST_IDLE) else $error("early");
  AST_AS_AVAIL: assert property ((state_ff == ST_IDLE) && (smode != SYNC_OFF)
    && as_avail && ((avail & rx_long) != 2'h0) |=> state_ff == ST_LINE) else $error("held");
  AST_CONCAT: assert property ((state_ff == ST_IDLE) && (smode == SYNC_CONCAT)
    && (pend_ff == 2'h0) && !all_rdy |=> state_ff == ST_IDLE) else $error("concat early");
  AST_SHORT: assert property ((state_ff == ST_IDLE) && (smode != SYNC_OFF)
    && (pend_ff == 2'h0) && !all_rdy && ((avail & rx_long) == 2'h0)
    |=> state_ff == ST_IDLE) else $error("short packet early");
  AST_MODE_OFF: assert property ((state_ff == ST_IDLE) && (smode == SYNC_OFF)
    && !rr_on && (pend_ff == 2'h0) |=> state_ff == ST_IDLE) else $error("forward while off");
  AST_RR_ROT: assert property ((state_ff == ST_IDLE) && (smode == SYNC_OFF) && rr_on
    && (avail == 2'h3) && (pend_ff == 2'h0) |=> src_ff != $past(last_src_ff))
    else $error("no rotation");
  AST_RR_GO: assert property ((state_ff == ST_IDLE) && (smode == SYNC_OFF) && rr_on
    && (avail != 2'h0) |=> (state_ff == ST_LINE) ##1 (rx_ready != 2'h0) || tx0_valid)
    else $error("rr stalled");
  AST_FAIL_SET: assert property (fail_evt |=> sync_fail_ff ##1 (sync_fail_ff || $past(rd_sts)))
    else $error("fail flag lost");
  AST_FAIL_CLR: assert property (rd_sts && !fail_evt |=> !sync_fail_ff)
    else $error("fail not cleared");
  AST_STS_OFF: assert property (smode == SYNC_OFF |=> !sync_sts_ff)
    else $error("status set while off");

  COV_RR: cover property (line_end && rr_on && (smode == SYNC_OFF));
  COV_GRP: cover property (grp_done);
  COV_FAIL: cover property (fail_evt);
  COV_REPL: cover property (tx1_valid && drain);
endmodule : vfm_mux

//--- vfm_pkg.sv
package vfm_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_PORT_DIS = 8'h20;
  localparam logic [7:0] IDX_MODE     = 8'h21;
  localparam logic [7:0] IDX_STS      = 8'h22;
  localparam logic [7:0] IDX_IRQ_STS  = 8'h30;
  localparam logic [7:0] IDX_IRQ_MSK  = 8'h31;
  localparam int         AW           = 12;

  localparam int BIT_P0_DIS   = 4;
  localparam int BIT_P1_DIS   = 5;
  localparam int BIT_RR       = 0;
  localparam int SYNC_LSB     = 2;
  localparam int BIT_AS_AVAIL = 6;
  localparam int BIT_REPL     = 7;
  localparam int BIT_SYNC_STS = 0;
  localparam int BIT_SYNC_FL  = 2;
  localparam int IRQ_FAIL     = 0;
  localparam int IRQ_LOCK     = 1;

  localparam logic [7:0] RST_PORT_DIS = 8'h30;
  localparam logic [7:0] RST_MODE     = 8'h01;
  localparam logic [7:0] WM_PORT_DIS  = 8'hF0;
  localparam logic [7:0] WM_MODE      = 8'hCF;
  localparam logic [1:0] IRQ_WM       = 2'h3;

  localparam int CLK_PERIOD_NS   = 4;
  localparam int SYNC_TIMEOUT_NS = 1000;
  localparam int SYNC_TIMEOUT_CYC = SYNC_TIMEOUT_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {SYNC_OFF, SYNC_BASIC, SYNC_INTERLEAVE, SYNC_CONCAT} vfm_sync_t;
  typedef enum logic {ST_IDLE, ST_LINE} vfm_state_t;
endpackage : vfm_pkg

//--- vfm_sink.sv
`timescale 1ns/1ps
// Receiving processor at an output port; stall holds its ready low, one cycle later, for as long as stall stays high
module vfm_sink (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic stall,
  output logic      ready
);
  logic ready_ff;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ready_ff <= 1'b0;
    else
      ready_ff <= !stall;
  assign ready = ready_ff;
endmodule : vfm_sink

//--- test_video_stream_forwarding_mux.sv
`timescale 1ns/1ps
module test_video_stream_forwarding_mux;
  import vfm_pkg::*;
  localparam logic [11:0] A_DIS = 4 * IDX_PORT_DIS;
  localparam logic [11:0] A_MODE = 4 * IDX_MODE;
  localparam logic [11:0] A_STS = 4 * IDX_STS;
  localparam logic [11:0] A_IST = 4 * IDX_IRQ_STS;
  localparam logic [11:0] A_MSK = 4 * IDX_IRQ_MSK;
  logic             pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0]      paddr = '0;
  logic [31:0]      pwdata = '0, prdata, tx0_data, tx1_data, r;
  logic             pready, pslverr, irq, e, tx0_valid, tx0_last, tx0_src, tx0_ready;
  logic             tx1_valid, tx1_last, tx1_ready;
  logic [1:0]       rx_valid = '0, rx_last = '0, rx_long = '0, rx_ready, stall = '0;
  logic [1:0][31:0] rx_data = '0;
  logic [10:0]      q[$];
  int               n_errors = 0, tests_run = 0;

  always #2 pclk = ~pclk;
  vfm_mux dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .irq, .rx_valid, .rx_data, .rx_last, .rx_long, .rx_ready, .tx0_valid,
    .tx0_data, .tx0_last, .tx0_src, .tx0_ready, .tx1_valid, .tx1_data, .tx1_last, .tx1_ready);
  vfm_sink snk0 (.pclk, .presetn, .stall(stall[0]), .ready(tx0_ready));
  vfm_sink snk1 (.pclk, .presetn, .stall(stall[1]), .ready(tx1_ready));

  // Collects drained output beats; sources drop valid once a beat is taken
  always @(posedge pclk)
  begin
    if (tx0_valid === 1'b1 && tx0_ready && (tx1_ready || !tx1_valid))
      q.push_back({tx0_last,
                   tx1_valid === 1'b1 && tx1_data === tx0_data && tx1_last === tx0_last,
                   tx0_src, tx0_data[7:0]});
    for (int i = 0; i < 2; i++)
      if (rx_valid[i] && rx_ready[i] === 1'b1)
        rx_valid[i] <= 1'b0;
  end

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits for the slave; only the watchdog ends a hung access
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
    chk("write error", 32'h0, {31'h0, e});
  endtask : wr

  task rd(input logic [11:0] a, input logic [7:0] x);
    apb(1'b0, a, 32'h0);
    chk("read data", {24'h0, x}, {7'h0, e, r[23:0]});
  endtask : rd

  task put(input logic [1:0] m, input logic [7:0] d, input logic lng);
    @(posedge pclk);
    for (int i = 0; i < 2; i++)
      if (m[i])
      begin
        rx_valid[i] <= 1'b1;
        rx_data[i] <= {24'h0, d + 8'(i)};
        rx_long[i] <= lng;
        rx_last[i] <= 1'b1;
      end
  endtask : put

  task get(input logic s, input logic [7:0] d, input logic lst, input logic rep);
    int n;
    n = 0;
    while (q.size() == 0 && n < 100)
    begin
      @(posedge pclk);
      n++;
    end
    chk("output beat", {21'h0, lst, rep, s, d}, q.size() > 0 ? {21'h0, q.pop_front()} : '1);
  endtask : get

  task held;
    repeat (20) @(posedge pclk);
    chk("beats while held", 32'h0, 32'(q.size()));
  endtask : held

  task give_verdict;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  initial
  begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    give_verdict();
  end

  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_DIS, 8'h30);
    rd(A_MODE, 8'h01);
    rd(A_STS, 8'h00);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped read", 32'h01000000, {7'h0, e, r[23:0]});
    put(2'b11, 8'h10, 1'b1);
    held();
    wr(A_DIS, 8'h20);
    get(1'b0, 8'h10, 1'b1, 1'b0);
    held();
    wr(A_DIS, 8'h00);
    get(1'b1, 8'h11, 1'b1, 1'b0);
    put(2'b01, 8'h20, 1'b1);
    get(1'b0, 8'h20, 1'b1, 1'b0);
    put(2'b11, 8'h30, 1'b1);
    get(1'b1, 8'h31, 1'b1, 1'b0);
    get(1'b0, 8'h30, 1'b1, 1'b0);
    wr(A_MODE, 8'h81);
    stall[1] <= 1'b1;
    put(2'b10, 8'h40, 1'b1);
    held();
    stall[1] <= 1'b0;
    get(1'b1, 8'h41, 1'b1, 1'b1);
    for (int m = 1; m < 4; m++)
    begin
      wr(A_MODE, 8'(m * 4));
      put(2'b10, 8'h50, 1'b1);
      held();
      put(2'b01, 8'h50, 1'b1);
      get(1'b0, 8'h50, m != 3, 1'b0);
      get(1'b1, 8'h51, 1'b1, 1'b0);
      rd(A_STS, 8'h01);
    end
    wr(A_MODE, 8'h00);
    put(2'b01, 8'h60, 1'b1);
    held();
    rd(A_STS, 8'h00);
    wr(A_MODE, 8'h01);
    get(1'b0, 8'h60, 1'b1, 1'b0);
    wr(A_MODE, 8'h44);
    put(2'b01, 8'h70, 1'b1);
    get(1'b0, 8'h70, 1'b1, 1'b0);
    put(2'b01, 8'h80, 1'b0);
    held();
    put(2'b10, 8'h80, 1'b0);
    get(1'b0, 8'h80, 1'b1, 1'b0);
    get(1'b1, 8'h81, 1'b1, 1'b0);
    wr(A_MODE, 8'h4C);
    put(2'b01, 8'h90, 1'b1);
    held();
    put(2'b10, 8'h90, 1'b1);
    get(1'b0, 8'h90, 1'b0, 1'b0);
    get(1'b1, 8'h91, 1'b1, 1'b0);
    wr(A_MODE, 8'h04);
    put(2'b11, 8'hA0, 1'b1);
    get(1'b0, 8'hA0, 1'b1, 1'b0);
    get(1'b1, 8'hA1, 1'b1, 1'b0);
    put(2'b01, 8'hB0, 1'b1);
    repeat (300) @(posedge pclk);
    rd(A_STS, 8'h04);
    rd(A_STS, 8'h00);
    wr(A_MODE, 8'h01);
    get(1'b0, 8'hB0, 1'b1, 1'b0);
    rd(A_IST, 8'h03);
    wr(A_MSK, 8'h01);
    repeat (2) @(posedge pclk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(A_MSK, 8'h00);
    repeat (2) @(posedge pclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(A_MSK, 8'h03);
    wr(A_IST, 8'h03);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rd(A_IST, 8'h00);
    give_verdict();
  end
endmodule : test_video_stream_forwarding_mux
